// ==== ddrsb_chk_sva.sv ====
// assertions on the memory pins of the ddr2 controller
module ddrsb_chk
	import ddrsb_pkg::*;
(
	// clock and reset
	input wire logic           clock,
	input wire logic           rstn,
	// watched ports
	input wire logic           burst8,
	input wire ddrsb_pins_type pins
);
	logic [2:0] code;
	logic       col;
	logic       rd;
	logic       sr_in;
	logic       in_sr;
	logic [2:0] gap;
	logic [3:0] open_b;
	logic [7:0] since;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	//////////////////////////////////////////
	// command decode
	assign code  = pins.cs_n ? CMD_NOP : {pins.ras_n, pins.cas_n, pins.we_n};
	assign col   = (code == CMD_READ) || (code == CMD_WRITE);
	assign rd    = code == CMD_READ;
	assign sr_in = (code == CMD_REF) && !pins.cke;
	// cycles since the last column command, saturating
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			gap <= 3'h7;
		else if (col)
			gap <= 3'h1;
		else if (gap != 3'h7)
			gap <= gap + 3'h1;
	end
	// which banks hold an open row
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			open_b <= 4'h0;
		else if (code == CMD_ACT)
			open_b[pins.ba] <= 1'b1;
		else if (code == CMD_PRE)
			open_b <= pins.addr[A10_BIT] ? 4'h0 : open_b & ~(4'h1 << pins.ba);
	end
	// cycles since leaving self refresh, held at zero inside it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			in_sr <= 1'b0;
			since <= 8'hff;
		end else begin
			in_sr <= sr_in || (in_sr && !pins.cke);
			if (sr_in || in_sr)
				since <= 8'h0;
			else if (since != 8'hff)
				since <= since + 8'h1;
		end
	end
	rd_bl4_a: assert property (rd && !burst8 |-> gap >= 3'h2)
		else $error("bl4 reads too close");
	rd_bl8_a: assert property (rd && burst8 |-> gap >= 3'h4)
		else $error("bl8 reads too close");
	wr_bl4_a: assert property (col && !rd && !burst8 |-> gap >= 3'h2)
		else $error("bl4 writes too close");
	wr_bl8_a: assert property (col && !rd && burst8 |-> gap >= 3'h4)
		else $error("bl8 writes too close");
	sr_idle_a: assert property (sr_in |-> open_b == 4'h0)
		else $error("self refresh with a bank open");
	odt_off_a: assert property (sr_in |-> !pins.odt && !$past(pins.odt))
		else $error("odt not off before self refresh");
	odt_back_a: assert property (pins.odt |-> since >= XSRD_CYC - 8'h1)
		else $error("odt back too soon after exit");
	rd_exit_a: assert property (rd |-> since >= XSRD_CYC - 8'h1)
		else $error("read too soon after exit");
	cmd_exit_a: assert property (code != CMD_NOP && !rd |-> since >= XSNR_CYC - 8'h1)
		else $error("command too soon after exit");
endmodule

// ==== ddrsb_ctrl.sv ====
// ddr2 host controller: seamless bursts, bank opening and self refresh
// How it works
// - bl4 reads issued every two cycles
// - bl8 reads issued every four cycles
// - seamless bursts across banks once activated
// - bl4 writes issued two cycles apart, at most two in a row
// - bl8 writes issued at best every eight cycles
// - all banks precharged before self refresh
// - odt low for turn-off delay first
// - odt back only after exit-to-read delay
// - reads wait exit-to-read delay
// - other commands wait exit-to-non-read delay
module ddrsb_ctrl
	import ddrsb_pkg::*;
(
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rstn,
	// configuration levels
	input  wire logic                 burst8,
	input  wire logic                 odt_enable,
	input  wire logic                 sr_request,
	// request stream
	input  wire logic                 req_valid,
	input  wire ddrsb_req_type        req,
	output logic                      req_ack,
	// write data stream
	input  wire logic                 wdata_valid,
	output logic                      wdata_ready,
	input  wire logic [WORD_W-1:0]    wdata,
	// read data
	output logic                      rdata_valid,
	output logic [WORD_W-1:0]         rdata,
	// status
	output logic                      in_self_refresh,
	// memory pins
	output ddrsb_pins_type            pins,
	output logic [WORD_W-1:0]         dq_out,
	output logic                      dq_oe,
	input  wire logic [WORD_W-1:0]    dq_in
);

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_PRE   = 3'b001,
		ST_ACT   = 3'b010,
		ST_SRPRE = 3'b011,
		ST_ODTOFF = 3'b100,
		ST_SELF  = 3'b101
	} ddrsb_state_type;

	////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta;
	logic rst_n;

	// two-flop release of the asynchronous reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// declarations
	ddrsb_state_type       state;
	logic [3:0]            bank_open;
	logic [12:0]           open_row [4];
	logic [2:0]            gap;
	logic                  last_write;
	logic [PIPE_LEN-1:0]   wpipe;
	logic [PIPE_LEN-1:0]   rpipe;
	logic [2:0]            reserved;
	logic [2:0]            words;
	logic                  row_hit;
	logic                  col_ok;
	logic                  dir_ok;
	logic                  data_ok;
	logic                  pipes_idle;
	logic                  issue_col;
	logic                  issue_pre;
	logic                  issue_act;
	logic                  sr_start;
	logic                  sr_exit;
	logic                  tmr_load;
	logic [7:0]            tmr_value;
	logic                  tmr_done;
	logic                  xsrd_done;
	logic                  xsnr_done;
	logic                  fifo_valid;
	logic [WORD_W-1:0]     fifo_data;
	logic [2:0]            fifo_count;
	logic                  pop;
	logic [PIPE_LEN-1:0]   next_mask;

	////////////////////////////////////////////////////////////////
	// helper blocks
	ddrsb_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_wfifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (wdata_valid),
		.in_ready  (wdata_ready),
		.in_data   (wdata),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data),
		.count     (fifo_count)
	);

	ddrsb_timer u_wait (
		.clock (clock),
		.rst_n (rst_n),
		.load  (tmr_load),
		.value (tmr_value),
		.done  (tmr_done)
	);

	ddrsb_timer u_xsrd (
		.clock (clock),
		.rst_n (rst_n),
		.load  (sr_exit),
		.value (XSRD_CYC),
		.done  (xsrd_done)
	);

	ddrsb_timer u_xsnr (
		.clock (clock),
		.rst_n (rst_n),
		.load  (sr_exit),
		.value (XSNR_CYC),
		.done  (xsnr_done)
	);

	////////////////////////////////////////////////////////////////
	// issue conditions
	assign words      = burst8 ? WORDS_BL8 : WORDS_BL4;
	assign row_hit    = bank_open[req.bank] && (open_row[req.bank] == req.row);
	assign pipes_idle = (wpipe == '0) && (rpipe == '0) && (gap == 3'h0);
	assign col_ok     = (gap == 3'h0);
	// turnaround only once the bus is quiet
	assign dir_ok     = (req.write == last_write) || ((wpipe == '0) && (rpipe == '0));
	// write data must already sit in the fifo
	assign data_ok    = !req.write || ({1'b0, fifo_count} >= 4'(reserved) + 4'(words));
	// exit delays gate the column command
	assign issue_col  = (state == ST_IDLE) && !sr_request && req_valid && !req_ack
		&& row_hit && col_ok && dir_ok && data_ok
		&& (req.write ? xsnr_done : xsrd_done);
	assign issue_pre  = (state == ST_IDLE) && !sr_request && req_valid && !req_ack
		&& !row_hit && bank_open[req.bank] && pipes_idle && xsnr_done;
	assign issue_act  = (state == ST_IDLE) && !sr_request && req_valid && !req_ack
		&& !bank_open[req.bank] && pipes_idle && xsnr_done;
	assign sr_start   = (state == ST_IDLE) && sr_request && pipes_idle && xsnr_done;
	assign sr_exit    = (state == ST_SELF) && !sr_request;
	assign pop        = wpipe[0];

	// fresh data-slot mask for a burst that starts after the given latency
	function automatic logic [PIPE_LEN-1:0] ddrsb_slots(input int lat, input logic [2:0] n);
		logic [PIPE_LEN-1:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < n) begin
				m[lat + i] = 1'b1;
			end
		end
		return m;
	endfunction

	assign next_mask = issue_col
		? (req.write ? ddrsb_slots(WRITE_LAT, words) : ddrsb_slots(READ_LAT + 1, words))
		: '0;

	// waits for precharge, activate and odt turn-off
	always_comb begin
		tmr_load  = 1'b0;
		tmr_value = RP_CYC;
		if (issue_pre || (sr_start && (bank_open != 4'h0))) begin
			tmr_load = 1'b1;
		end else if (issue_act) begin
			tmr_load  = 1'b1;
			tmr_value = RCD_CYC;
		end else if ((sr_start && (bank_open == 4'h0)) || ((state == ST_SRPRE) && tmr_done)) begin
			tmr_load  = 1'b1;
			tmr_value = AOFD_CYC;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (sr_start) begin
						state <= (bank_open != 4'h0) ? ST_SRPRE : ST_ODTOFF;
					end else if (issue_pre) begin
						state <= ST_PRE;
					end else if (issue_act) begin
						state <= ST_ACT;
					end
				end
				ST_PRE, ST_ACT: begin
					if (tmr_done) begin
						state <= ST_IDLE;
					end
				end
				ST_SRPRE: begin
					if (tmr_done) begin
						state <= ST_ODTOFF;
					end
				end
				ST_ODTOFF: begin
					if (tmr_done && !tmr_load) begin
						state <= ST_SELF;
					end
				end
				ST_SELF: begin
					if (!sr_request) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// bank and row bookkeeping
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bank_open <= 4'h0;
			for (int b = 0; b < 4; b++) begin
				open_row[b] <= 13'h0000;
			end
		end else if (sr_start) begin
			bank_open <= 4'h0;
		end else if (issue_pre) begin
			bank_open[req.bank] <= 1'b0;
		end else if (issue_act) begin
			bank_open[req.bank] <= 1'b1;
			open_row[req.bank]  <= req.row;
		end
	end

	// column spacing, direction and request acknowledge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gap        <= 3'h0;
			last_write <= 1'b0;
			req_ack    <= 1'b0;
		end else begin
			req_ack <= issue_col;
			if (issue_col) begin
				gap        <= words - 3'h1;
				last_write <= req.write;
			end else if (gap != 3'h0) begin
				gap <= gap - 3'h1;
			end
		end
	end

	// data slot pipes and write reservations
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wpipe    <= '0;
			rpipe    <= '0;
			reserved <= 3'h0;
		end else begin
			// back-to-back slots merge into one stream
			wpipe    <= (wpipe >> 1) | (req.write ? next_mask : '0);
			rpipe    <= (rpipe >> 1) | (req.write ? '0 : next_mask);
			reserved <= reserved + ((issue_col && req.write) ? words : 3'h0) - {2'h0, pop};
		end
	end

	////////////////////////////////////////////////////////////////
	// command pins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
				ba: 2'h0, addr: 13'h0000, odt: 1'b0};
		end else begin
			pins <= ddrsb_put(pins, CMD_NOP, pins.ba, pins.addr);
			pins.cke <= (state != ST_SELF) || !sr_request;
			// odt only with exit-to-read delay met
			pins.odt <= odt_enable && xsrd_done && !sr_request
				&& (state == ST_IDLE || state == ST_PRE || state == ST_ACT);
			if (issue_col) begin
				pins <= ddrsb_put(pins, req.write ? CMD_WRITE : CMD_READ, req.bank,
					{3'h0, req.col});
			end else if (issue_pre) begin
				pins <= ddrsb_put(pins, CMD_PRE, req.bank, 13'h0000);
			end else if (issue_act) begin
				pins <= ddrsb_put(pins, CMD_ACT, req.bank, req.row);
			end else if (sr_start && (bank_open != 4'h0)) begin
				pins <= ddrsb_put(pins, CMD_PRE, 2'h0, 13'(1 << A10_BIT));
				pins.odt <= 1'b0;
			end else if ((state == ST_ODTOFF) && tmr_done && !tmr_load) begin
				// enter self refresh with cke low
				pins      <= ddrsb_put(pins, CMD_REF, 2'h0, 13'h0000);
				pins.cke  <= 1'b0;
				pins.odt  <= 1'b0;
			end else if ((state == ST_SELF) && sr_request) begin
				pins.cke <= 1'b0;
				pins.odt <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// data pins and read capture
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dq_out      <= '0;
			dq_oe       <= 1'b0;
			rdata       <= '0;
			rdata_valid <= 1'b0;
		end else begin
			dq_oe       <= wpipe[0] && fifo_valid;
			rdata_valid <= rpipe[0];
			if (wpipe[0]) begin
				dq_out <= fifo_data;
			end
			if (rpipe[0]) begin
				rdata <= dq_in;
			end
		end
	end

	// self refresh status
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_self_refresh <= 1'b0;
		end else begin
			in_self_refresh <= (state == ST_SELF) && sr_request;
		end
	end

endmodule

// ==== ddrsb_ctrl_tb.sv ====
// self-checking bench for the ddr2 controller
module ddrsb_ctrl_tb
	import ddrsb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic        b8;
		logic        wr;
		logic [1:0]  bank;
		logic [9:0]  col;
		logic [31:0] data;
	} ddrsb_row_type;
	logic              clock, rstn, burst8, odt_enable, sr_request;
	logic              req_valid, req_ack, wdata_valid, wdata_ready;
	logic              rdata_valid, in_self_refresh, dq_oe, chained;
	ddrsb_req_type     req;
	ddrsb_pins_type    pins;
	logic [WORD_W-1:0] wdata, rdata, dq_out, dq_in;
	logic [31:0]       expq [$];
	int                mismatches, compares, n;
	time               t_ack, t_exit;
	// requests beside the data they write or should read back
	ddrsb_row_type rows [8] = '{
		'{1'b0, 1'b1, 2'h0, 10'h0, 32'h1000_0000},
		'{1'b0, 1'b1, 2'h1, 10'h0, 32'h2000_0000},
		'{1'b0, 1'b0, 2'h0, 10'h0, 32'h1000_0000},
		'{1'b0, 1'b0, 2'h1, 10'h0, 32'h2000_0000},
		'{1'b0, 1'b0, 2'h0, 10'h0, 32'h1000_0000},
		'{1'b1, 1'b1, 2'h2, 10'h8, 32'h3000_0000},
		'{1'b1, 1'b0, 2'h2, 10'h8, 32'h3000_0000},
		'{1'b1, 1'b0, 2'h2, 10'h8, 32'h3000_0000}
	};
	//////////////////////////////////////////
	// verdict and end of run
	task automatic end_of_test();
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// a wait that ran out
	task automatic timeout();
		mismatches++;
		end_of_test();
	endtask
	// count a comparison and report a mismatch
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// present one request, hold it until acknowledged
	task automatic send(input ddrsb_row_type r, input bit keep);
		req <= {r.wr, r.bank, 11'h0, r.bank, r.col};
		req_valid <= 1'b1;
		if (!r.wr)
			for (int k = 0; k < (burst8 ? 4 : 2); k++)
				expq.push_back(r.data + 32'(k));
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (req_ack !== 1'b1 && n < 400);
		if (req_ack !== 1'b1)
			timeout();
		if (chained)
			check("column spacing", 32'(burst8 ? 4 : 2), 32'(($time - t_ack) / 50));
		t_ack = $time;
		chained = keep;
		if (!keep) begin
			req_valid <= 1'b0;
			@(posedge clock);
		end
	endtask
	// hand one word to the write buffer
	task automatic push(input logic [31:0] w, input bit last);
		wdata <= w;
		wdata_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wdata_ready !== 1'b1 && n < 400);
		if (wdata_ready !== 1'b1)
			timeout();
		if (last)
			wdata_valid <= 1'b0;
	endtask
	// bounded wait for a status level
	task automatic wait_until(ref logic s, input logic v);
		for (n = 0; n < 400 && s !== v; n++)
			@(posedge clock);
		if (s !== v)
			timeout();
	endtask
	// let outstanding read words come back
	task automatic drain();
		for (n = 0; n < 100 && expq.size() > 0; n++)
			@(posedge clock);
		check("words outstanding", 32'h0, 32'(expq.size()));
		repeat (8) @(posedge clock);
	endtask
	// clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	ddrsb_ctrl dut (
		.clock, .rstn, .burst8, .odt_enable, .sr_request, .req_valid, .req, .req_ack,
		.wdata_valid, .wdata_ready, .wdata, .rdata_valid, .rdata, .in_self_refresh,
		.pins, .dq_out, .dq_oe, .dq_in
	);
	ddrsb_mem u_mem (.clock, .burst8, .pins, .dq_out, .dq_oe, .dq_in);
	// every returned word is matched against the expected queue
	always @(posedge clock)
		if (rdata_valid === 1'b1)
			check("read word", expq.size() ? expq.pop_front() : 32'hdead_beef, rdata);
	// main sequence
	initial begin
		rstn = 1'b0;
		burst8 = 1'b0;
		odt_enable = 1'b1;
		sr_request = 1'b0;
		req_valid = 1'b0;
		req = '0;
		wdata_valid = 1'b0;
		wdata = 32'h0;
		chained = 1'b0;
		mismatches = 0;
		compares = 0;
		repeat (6) @(posedge clock);
		check("cke in reset", 32'h0, 32'(pins.cke));
		check("select in reset", 32'h1, 32'(pins.cs_n));
		check("dq drive in reset", 32'h0, 32'(dq_oe));
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		// ordinary bursts, reads chained where the next row allows
		for (int i = 0; i < 8; i++) begin
			if (rows[i].b8 !== burst8) begin
				drain();
				burst8 <= rows[i].b8;
				@(posedge clock);
			end
			if (rows[i].wr)
				for (int k = 0; k < (rows[i].b8 ? 4 : 2); k++)
					push(rows[i].data + 32'(k), k == (rows[i].b8 ? 3 : 1));
			send(rows[i], i < 7 && !rows[i].wr && !rows[i + 1].wr && rows[i + 1].b8 == rows[i].b8);
		end
		// fill the write buffer until it refuses, then empty it by chained writes
		drain();
		burst8 <= 1'b0;
		for (int k = 0; k < 4; k++)
			push(32'h4000_0000 + 32'(k), k == 3);
		repeat (2) @(posedge clock);
		check("buffer refuses", 32'h0, 32'(wdata_ready));
		send('{1'b0, 1'b1, 2'h3, 10'h0, 32'h0}, 1'b1);
		send('{1'b0, 1'b1, 2'h3, 10'h4, 32'h0}, 1'b0);
		send('{1'b0, 1'b0, 2'h3, 10'h0, 32'h4000_0000}, 1'b1);
		send('{1'b0, 1'b0, 2'h3, 10'h4, 32'h4000_0002}, 1'b0);
		// self refresh with banks open, then a read after the exit
		drain();
		sr_request <= 1'b1;
		wait_until(in_self_refresh, 1'b1);
		check("cke in self refresh", 32'h0, 32'(pins.cke));
		check("odt in self refresh", 32'h0, 32'(pins.odt));
		repeat (20) @(posedge clock);
		check("cke held low", 32'h0, 32'(pins.cke));
		sr_request <= 1'b0;
		t_exit = $time;
		wait_until(in_self_refresh, 1'b0);
		send('{1'b0, 1'b0, 2'h3, 10'h4, 32'h4000_0002}, 1'b0);
		check("exit to read", 32'h1, 32'(($time - t_exit) / 50 >= XSRD_CYC));
		drain();
		check("buffer ready", 32'h1, 32'(wdata_ready));
		end_of_test();
	end
endmodule

bind ddrsb_ctrl ddrsb_chk u_chk (.clock(clock), .rstn(rstn), .burst8(burst8), .pins(pins));

// ==== ddrsb_fifo.sv ====
// small fifo for write data with valid and ready on both sides
module ddrsb_fifo
	import ddrsb_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	// fill level
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////
	// handshake terms
	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers, level and flags
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			count     <= (AW+1)'(count + push - pop);
			in_ready  <= (AW+1)'(count + push - pop) != (AW+1)'(DEPTH);
			out_valid <= (AW+1)'(count + push - pop) != '0;
		end
	end

endmodule

// ==== ddrsb_mem.sv ====
// behavioural ddr2 memory answering the controller pins
module ddrsb_mem
	import ddrsb_pkg::*;
(
	// clock and preset burst mode
	input  wire logic              clock,
	input  wire logic              burst8,
	// controller side
	input  wire ddrsb_pins_type    pins,
	input  wire logic [WORD_W-1:0] dq_out,
	input  wire logic              dq_oe,
	output logic [WORD_W-1:0]      dq_in
);
	logic [WORD_W-1:0] mem [64];
	logic [6:0]        slot [8];
	logic [7:0]        busy = 8'h0;
	logic [3:0]        open_b = 4'h0;
	logic [2:0]        code;
	//////////////////////////////////////////
	// command decode
	assign code = pins.cs_n ? CMD_NOP : {pins.ras_n, pins.cas_n, pins.we_n};
	// bank state, burst queue and data transfer
	always @(posedge clock) begin
		busy <= busy >> 1;
		for (int k = 0; k < 7; k++)
			slot[k] <= slot[k + 1];
		if (code == CMD_ACT)
			open_b[pins.ba] <= 1'b1;
		if (code == CMD_PRE)
			open_b <= pins.addr[A10_BIT] ? 4'h0 : open_b & ~(4'h1 << pins.ba);
		// any open bank, each burst queued right behind the last
		// first word one cycle past the nominal latency, where the registered data path puts it
		if ((code == CMD_READ || code == CMD_WRITE) && open_b[pins.ba])
			for (int k = 0; k < (burst8 ? 4 : 2); k++) begin
				busy[k + 2] <= 1'b1;
				slot[k + 2] <= {!pins.we_n, pins.ba, pins.addr[4:1] + 4'(k)};
			end
		// head of queue: take a written word or drive a read word
		if (busy[0] && slot[0][6])
			mem[slot[0][5:0]] <= dq_oe ? dq_out : ~dq_out;
		dq_in <= (busy[0] && !slot[0][6]) ? mem[slot[0][5:0]] : ~dq_in;
	end
endmodule

// ==== ddrsb_pkg.sv ====
// shared constants, types and helpers for the ddr2 burst and self refresh controller
package ddrsb_pkg;

	// clock and latency
	localparam int CLK_PERIOD_NS = 50;
	localparam int CAS_LAT       = 3;
	localparam int ADD_LAT       = 0;
	localparam int READ_LAT      = ADD_LAT + CAS_LAT;
	localparam int WRITE_LAT     = READ_LAT - 1;
	localparam int PIPE_LEN      = 12;

	// timing figures in their own units
	localparam int T_RP_NS    = 15;
	localparam int T_RCD_NS   = 15;
	localparam int T_AOFD_NS  = 10;
	localparam int T_XSNR_NS  = 200;
	localparam int T_XSRD_CK  = 200;

	// least times round up to whole cycles, never below one
	function automatic int ddrsb_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [7:0] RP_CYC   = 8'(ddrsb_cycles(T_RP_NS));
	localparam logic [7:0] RCD_CYC  = 8'(ddrsb_cycles(T_RCD_NS));
	localparam logic [7:0] AOFD_CYC = 8'(ddrsb_cycles(T_AOFD_NS));
	localparam logic [7:0] XSNR_CYC = 8'(ddrsb_cycles(T_XSNR_NS));
	localparam logic [7:0] XSRD_CYC = 8'(T_XSRD_CK);

	// burst geometry: one controller word carries two ddr beats
	localparam logic [2:0] WORDS_BL4 = 3'h2;
	localparam logic [2:0] WORDS_BL8 = 3'h4;
	localparam int         A10_BIT   = 10;
	localparam int         FIFO_DEPTH = 4;
	localparam int         WORD_W     = 32;

	// command codes as {ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		CMD_ACT   = 3'b011,
		CMD_READ  = 3'b101,
		CMD_WRITE = 3'b100,
		CMD_PRE   = 3'b010,
		CMD_REF   = 3'b001,
		CMD_NOP   = 3'b111
	} ddrsb_cmd_type;

	// user request
	typedef struct packed {
		logic        write;
		logic [1:0]  bank;
		logic [12:0] row;
		logic [9:0]  col;
	} ddrsb_req_type;

	// memory command pins
	typedef struct packed {
		logic        cke;
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [1:0]  ba;
		logic [12:0] addr;
		logic        odt;
	} ddrsb_pins_type;

	// places a command code, bank and address on the pins, cke and odt kept
	function automatic ddrsb_pins_type ddrsb_put(input ddrsb_pins_type p, input ddrsb_cmd_type c,
		input logic [1:0] ba, input logic [12:0] addr);
		ddrsb_pins_type r;
		r = p;
		r.cs_n = 1'b0;
		{r.ras_n, r.cas_n, r.we_n} = c;
		r.ba = ba;
		r.addr = addr;
		return r;
	endfunction

endpackage

// ==== ddrsb_timer.sv ====
// loadable down counter that flags when a wait has run out
module ddrsb_timer
	import ddrsb_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// load a fresh wait
	input  wire logic       load,
	input  wire logic [7:0] value,
	// wait over
	output logic            done
);
	logic [7:0] left;

	// count down to zero after each load
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left <= 8'h00;
			done <= 1'b1;
		end else if (load) begin
			left <= value;
			done <= 1'b0;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
			done <= (left == 8'h01);
		end
	end

endmodule
